// [rtl/hbc_pkg.sv]
// Package for the host bus control block: widths, codes, strap timing.
// Assumes one 250 MHz clock domain and a synchronous active-high reset.
`default_nettype none

package hbc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W      = 16;
    localparam int ADDR_W      = 11;
    localparam int ADDR_LO_W   = 8;
    localparam int ADDR_HI_W   = 3;
    localparam int BYTE_W      = 8;

    // ------------------------------------------------------------
    // Address field positions on the shared lines
    // ------------------------------------------------------------
    localparam int ADDR16_LSB  = 2;   // Wide mode address starts at line 2
    localparam int ADDR16_MSB  = 10;
    localparam int BE_LSB      = 12;  // Byte enables on lines 15..12
    localparam int BE_W        = 4;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic WAKE_POL_RESET = 1'b0;   // Active low after reset
    localparam logic EEPROM_RESET   = 1'b0;
    localparam int   CLK_MHZ        = 250;
    localparam int   STRAP_SETTLE_NS = 40;    // Strap settle after release
    localparam int   STRAP_SETTLE_CYC =
        (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] STRAP_SETTLE_CNT = 4'(STRAP_SETTLE_CYC);

    // ------------------------------------------------------------
    // Access phase states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_READ  = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_DONE  = 4'b1000
    } hbc_state_type;

endpackage : hbc_pkg

`default_nettype wire

// [rtl/hbc_sync_if.sv]
// Interface carrying synchronised host strobes between design modules.
// Assumes both ends share the single design clock.
`default_nettype none

interface hbc_sync_if;
    logic sel;        // Device selected, active high
    logic rd;         // Read strobe active, high
    logic wr;         // Write strobe active, high
    logic cmd;        // Command type level
    logic wake_pin;   // Synchronised wake/strap pin level

    modport src (output sel, output rd, output wr, output cmd,
                 output wake_pin);
    modport dst (input sel, input rd, input wr, input cmd,
                 input wake_pin);
endinterface : hbc_sync_if

`default_nettype wire

// [rtl/hbc_sync.sv]
// Two-flop synchronisers for the asynchronous host control pins.
// Assumes pins are unrelated to clk; outputs are active-high levels.
`default_nettype none

module hbc_sync
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic device_select_n,
    input  wire logic host_read_strobe_n,
    input  wire logic host_write_strobe_n,
    input  wire logic cmd_type,
    input  wire logic wake_pin_in,
    hbc_sync_if.src   sync
);
    logic [4:0] stage1;
    logic [4:0] stage2;

    // ------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------
    // First stage read only by second stage
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage1 <= 5'h07;
            stage2 <= 5'h07;
        end
        else
        begin
            stage1 <= {wake_pin_in, cmd_type, host_write_strobe_n,
                       host_read_strobe_n, device_select_n};
            stage2 <= stage1;
        end
    end

    // Strobes inverted to active-high levels
    assign sync.sel      = ~stage2[0];
    assign sync.rd       = ~stage2[1];
    assign sync.wr       = ~stage2[2];
    assign sync.cmd      = stage2[3];
    assign sync.wake_pin = stage2[4];

endmodule : hbc_sync

`default_nettype wire

// [rtl/hbc_top.sv]
// Host bus control: strobe qualification, shared bus steering,
// interrupt pin, wake request pin and EEPROM strap capture.
// Assumes the core supplies read data, interrupt status and wake events
// on clk, and consumes write data and addresses from this block.
//
// How it works
// - irq_out_n is driven low while any interrupt status bit is set.
// - A wake event from the core asserts the wake request output.
// - The wake output level is programmable and defaults to active low.
// - The wake pin level is latched after reset as the EEPROM strap.
// - Command type low means data, high means address on the bus.
`default_nettype none

module hbc_top
    import hbc_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        device_select_n,
    input  wire logic                        host_read_strobe_n,
    input  wire logic                        host_write_strobe_n,
    input  wire logic                        cmd_type,
    input  wire logic [hbc_pkg::DATA_W-1:0]  shared_bus_lines_in,
    output logic      [hbc_pkg::DATA_W-1:0]  shared_bus_lines_out,
    output logic                             shared_bus_lines_oe_n,
    input  wire logic                        bus_mode_8bit,
    input  wire logic [hbc_pkg::DATA_W-1:0]  core_read_data,
    output logic      [hbc_pkg::DATA_W-1:0]  core_write_data,
    output logic                             core_write_pulse,
    output logic                             core_read_pulse,
    output logic      [hbc_pkg::ADDR_W-1:0]  core_addr,
    output logic      [hbc_pkg::BE_W-1:0]    core_byte_en,
    input  wire logic                        irq_status_any,
    output logic                             irq_out_n,
    input  wire logic                        wake_event,
    input  wire logic                        wake_clear,
    input  wire logic                        wake_pol_high,
    input  wire logic                        wake_pin_in,
    output logic                             wake_request_out,
    output logic                             wake_request_oe_n,
    output logic                             eeprom_present,
    output logic                             strap_valid
);
    hbc_sync_if sync ();

    hbc_state_type state;
    hbc_state_type next_state;
    logic          addr_hi_phase;
    logic          wake_pending;
    logic [3:0]    settle_cnt;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    hbc_sync u_sync
    (
        .clk                 (clk),
        .rst                 (rst),
        .device_select_n     (device_select_n),
        .host_read_strobe_n  (host_read_strobe_n),
        .host_write_strobe_n (host_write_strobe_n),
        .cmd_type            (cmd_type),
        .wake_pin_in         (wake_pin_in),
        .sync                (sync)
    );

    // ------------------------------------------------------------
    // Access state machine
    // ------------------------------------------------------------
    // One action per strobe; wait for strobe release before next
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
            begin
                if (sync.sel && sync.rd)
                    next_state = ST_READ;
                else if (sync.sel && sync.wr)
                    next_state = ST_WRITE;
            end
            ST_READ:  next_state = ST_DONE;
            ST_WRITE: next_state = ST_DONE;
            ST_DONE:
            begin
                if (!sync.rd && !sync.wr)
                    next_state = ST_IDLE;
            end
            default:  next_state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------
    // Core pulses
    // ------------------------------------------------------------
    // Read pulse fetches data; write pulse only for data writes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            core_read_pulse  <= 1'b0;
            core_write_pulse <= 1'b0;
        end
        else
        begin
            core_read_pulse  <= (state == ST_READ) && !sync.cmd;
            core_write_pulse <= (state == ST_WRITE) && !sync.cmd;
        end
    end

    // ------------------------------------------------------------
    // Address and write data capture
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            core_addr       <= '0;
            core_byte_en    <= '0;
            core_write_data <= '0;
            addr_hi_phase   <= 1'b0;
        end
        else if (state == ST_WRITE)
        begin
            if (!sync.cmd)
                core_write_data <= shared_bus_lines_in;
            else if (!bus_mode_8bit)
            begin
                core_addr[ADDR16_MSB:ADDR16_LSB] <=
                    shared_bus_lines_in[ADDR16_MSB:ADDR16_LSB];
                core_addr[ADDR16_LSB-1:0] <= '0;
                core_byte_en <= shared_bus_lines_in[BE_LSB +: BE_W];
            end
            else if (!addr_hi_phase)
            begin
                core_addr[ADDR_LO_W-1:0] <=
                    shared_bus_lines_in[ADDR_LO_W-1:0];
                addr_hi_phase <= 1'b1;
            end
            else
            begin
                core_addr[ADDR_W-1:ADDR_LO_W] <=
                    shared_bus_lines_in[ADDR_HI_W-1:0];
                addr_hi_phase <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Shared bus drive
    // ------------------------------------------------------------
    // Drive only while selected and reading; data held from core
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            shared_bus_lines_out  <= '0;
            shared_bus_lines_oe_n <= 1'b1;
        end
        else
        begin
            if (core_read_pulse)
                shared_bus_lines_out <= core_read_data;
            shared_bus_lines_oe_n <=
                !(sync.sel && sync.rd && !sync.cmd);
        end
    end

    // ------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------
    // Open-drain style: low while any status bit set
    always_ff @(posedge clk)
    begin
        if (rst)
            irq_out_n <= 1'b1;
        else
            irq_out_n <= !irq_status_any;
    end

    // ------------------------------------------------------------
    // Wake request
    // ------------------------------------------------------------
    // Sticky wake; new event beats a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            wake_pending <= 1'b0;
        else if (wake_event)
            wake_pending <= 1'b1;
        else if (wake_clear)
            wake_pending <= 1'b0;
    end

    // Polarity applied; pin released until strap is taken
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wake_request_out  <= !WAKE_POL_RESET;
            wake_request_oe_n <= 1'b1;
        end
        else
        begin
            wake_request_out  <= wake_pol_high ? wake_pending
                                               : !wake_pending;
            wake_request_oe_n <= !strap_valid;
        end
    end

    // ------------------------------------------------------------
    // EEPROM strap capture
    // ------------------------------------------------------------
    // Sample pin once settle count ends after reset release
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            settle_cnt     <= STRAP_SETTLE_CNT;
            strap_valid    <= 1'b0;
            eeprom_present <= EEPROM_RESET;
        end
        else if (!strap_valid)
        begin
            if (settle_cnt != 4'h0)
                settle_cnt <= settle_cnt - 4'h1;
            else
            begin
                eeprom_present <= sync.wake_pin;
                strap_valid    <= 1'b1;
            end
        end
    end

endmodule : hbc_top

`default_nettype wire

// [dv/hbc_asserts.sv]
// Checker for the host bus control block: pins, pulses, wake, strap.
// Assumes binding into hbc_top; one clock, synchronous reset.
`default_nettype none

module hbc_asserts
    import hbc_pkg::*;
(
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic                       device_select_n,
    input wire logic                       host_read_strobe_n,
    input wire logic                       cmd_type,
    input wire logic [hbc_pkg::DATA_W-1:0] shared_bus_lines_out,
    input wire logic                       shared_bus_lines_oe_n,
    input wire logic [hbc_pkg::DATA_W-1:0] core_read_data,
    input wire logic                       core_write_pulse,
    input wire logic                       core_read_pulse,
    input wire logic                       irq_status_any,
    input wire logic                       irq_out_n,
    input wire logic                       wake_event,
    input wire logic                       wake_clear,
    input wire logic                       wake_pol_high,
    input wire logic                       wake_request_out,
    input wire logic                       wake_request_oe_n,
    input wire logic                       eeprom_present,
    input wire logic                       strap_valid
);
    import hbc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Interrupt pin follows status with one cycle of lag
    a_irq_assert: assert property (
        irq_status_any |=> !irq_out_n) else $error("irq not driven");
    a_irq_release: assert property (
        !irq_status_any |=> irq_out_n) else $error("irq not released");
    // Bus steering and strobe qualification
    a_bus_on_read: assert property (
        !shared_bus_lines_oe_n |-> $past(!device_select_n &&
        !host_read_strobe_n, 2) || $past(!device_select_n &&
        !host_read_strobe_n, 3)) else $error("bus driven off read");
    a_write_data: assert property (
        core_write_pulse |-> !$past(cmd_type, 4) &&
        !$past(device_select_n, 4)) else $error("bad write pulse");
    a_read_return: assert property (
        core_read_pulse |=> shared_bus_lines_out == $past(core_read_data))
        else $error("read data not returned");
    a_single_pulse: assert property (
        core_write_pulse |=> !core_write_pulse) else $error("pulse twice");
    // Wake pin level and strap capture
    a_wake_set: assert property (
        wake_event |-> ##2 wake_request_out == wake_pol_high)
        else $error("wake not asserted");
    a_wake_idle: assert property (
        wake_clear && !wake_event |-> ##2 wake_request_out ==
        !wake_pol_high) else $error("wake idle level wrong");
    a_strap_hold: assert property (
        strap_valid |=> strap_valid && $stable(eeprom_present))
        else $error("strap changed");
    a_strap_hiz: assert property (
        !strap_valid |-> wake_request_oe_n) else $error("wake pin early");

    c_read: cover property (core_read_pulse);
    c_write: cover property (core_write_pulse);
    c_wake: cover property (wake_event ##2 wake_request_out);
endmodule : hbc_asserts

bind hbc_top hbc_asserts i_hbc_asserts
(
    .clk                   (clk),
    .rst                   (rst),
    .device_select_n       (device_select_n),
    .host_read_strobe_n    (host_read_strobe_n),
    .cmd_type              (cmd_type),
    .shared_bus_lines_out  (shared_bus_lines_out),
    .shared_bus_lines_oe_n (shared_bus_lines_oe_n),
    .core_read_data        (core_read_data),
    .core_write_pulse      (core_write_pulse),
    .core_read_pulse       (core_read_pulse),
    .irq_status_any        (irq_status_any),
    .irq_out_n             (irq_out_n),
    .wake_event            (wake_event),
    .wake_clear            (wake_clear),
    .wake_pol_high         (wake_pol_high),
    .wake_request_out      (wake_request_out),
    .wake_request_oe_n     (wake_request_oe_n),
    .eeprom_present        (eeprom_present),
    .strap_valid           (strap_valid)
);

`default_nettype wire

// [dv/hbc_host.sv]
// Host processor model: select, strobes, command type, bus lines.
// Assumes the bench clock paces it; pins change on falling edges.
`default_nettype none

module hbc_host
(
    input  wire logic        clk,
    output logic             device_select_n,
    output logic             host_read_strobe_n,
    output logic             host_write_strobe_n,
    output logic             cmd_type,
    output logic [15:0]      shared_bus_lines_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle select and strobes at the pull-up level, command type and lines low
    initial
    begin
        device_select_n = 1'b1;
        host_read_strobe_n = 1'b1;
        host_write_strobe_n = 1'b1;
        cmd_type = 1'b0;
        shared_bus_lines_in = 16'h0000;
    end

    // One access: select, then strobe held 8 cycles, select dropped 1 cycle after strobe release, then 4 idle
    task automatic access(input logic w, s, c, input logic [15:0] d);
        @(negedge clk);
        device_select_n = !s;
        cmd_type = c;
        shared_bus_lines_in = d;
        @(negedge clk);
        if (w)
            host_write_strobe_n = 1'b0;
        else
            host_read_strobe_n = 1'b0;
        repeat (8) @(negedge clk);
        host_read_strobe_n = 1'b1;
        host_write_strobe_n = 1'b1;
        @(negedge clk);
        device_select_n = 1'b1;
        cmd_type = 1'b0;                           // Back to pull-down
        shared_bus_lines_in = ~d;                  // Released lines
        repeat (4) @(negedge clk);
    endtask : access
endmodule : hbc_host

`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the host bus control block.
// Assumes hbc_top, its checker and the host model are compiled first.
`default_nettype none

module testbench;
    import hbc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0, rst = 1'b1, bus_mode_8bit = 1'b0;
    logic irq_status_any = 1'b0, wake_event = 1'b0, wake_clear = 1'b0;
    logic wake_pol_high = 1'b0, wake_pin_in = 1'b1, oe_seen;
    logic device_select_n, host_read_strobe_n, host_write_strobe_n;
    logic cmd_type, shared_bus_lines_oe_n, core_write_pulse;
    logic core_read_pulse, irq_out_n, wake_request_out;
    logic wake_request_oe_n, eeprom_present, strap_valid;
    logic [15:0] shared_bus_lines_in, shared_bus_lines_out;
    logic [15:0] core_write_data, core_read_data = 16'hc33c;
    logic [10:0] core_addr;
    logic [3:0]  core_byte_en;
    int          err_count = 0, num_checks = 0, wcnt, rcnt;

    hbc_top i_hbc_top
    (
        .clk                   (clk),
        .rst                   (rst),
        .device_select_n       (device_select_n),
        .host_read_strobe_n    (host_read_strobe_n),
        .host_write_strobe_n   (host_write_strobe_n),
        .cmd_type              (cmd_type),
        .shared_bus_lines_in   (shared_bus_lines_in),
        .shared_bus_lines_out  (shared_bus_lines_out),
        .shared_bus_lines_oe_n (shared_bus_lines_oe_n),
        .bus_mode_8bit         (bus_mode_8bit),
        .core_read_data        (core_read_data),
        .core_write_data       (core_write_data),
        .core_write_pulse      (core_write_pulse),
        .core_read_pulse       (core_read_pulse),
        .core_addr             (core_addr),
        .core_byte_en          (core_byte_en),
        .irq_status_any        (irq_status_any),
        .irq_out_n             (irq_out_n),
        .wake_event            (wake_event),
        .wake_clear            (wake_clear),
        .wake_pol_high         (wake_pol_high),
        .wake_pin_in           (wake_pin_in),
        .wake_request_out      (wake_request_out),
        .wake_request_oe_n     (wake_request_oe_n),
        .eeprom_present        (eeprom_present),
        .strap_valid           (strap_valid)
    );

    hbc_host i_hbc_host
    (
        .clk                 (clk),
        .device_select_n     (device_select_n),
        .host_read_strobe_n  (host_read_strobe_n),
        .host_write_strobe_n (host_write_strobe_n),
        .cmd_type            (cmd_type),
        .shared_bus_lines_in (shared_bus_lines_in)
    );

    always #2 clk = ~clk;

    // Count core pulses and bus drive where outputs have settled
    always @(negedge clk)
    begin
        if (core_write_pulse === 1'b1) wcnt++;
        if (core_read_pulse === 1'b1) rcnt++;
        if (shared_bus_lines_oe_n === 1'b0) oe_seen = 1'b1;
    end

    task automatic chk(input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic go(input logic w, s, c, input logic [15:0] d);
        @(negedge clk);
        wcnt = 0;
        rcnt = 0;
        oe_seen = 1'b0;
        i_hbc_host.access(w, s, c, d);
    endtask : go

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic t_strap(input logic p);
        rst = 1'b1;
        wake_pol_high = 1'b0;
        wake_pin_in = p;
        tick(12);
        rst = 1'b0;
        for (int n = 0; n < 40 && strap_valid !== 1'b1; n++) tick(1);
        chk(strap_valid, 1'b1);
        chk(eeprom_present, p);
        chk(wake_request_out, 1'b1);
        tick(2);
        chk(wake_request_oe_n, 1'b0);
        wake_pin_in = ~p;
        tick(3);
        chk(eeprom_present, p);
    endtask : t_strap

    task automatic t_irq();
        irq_status_any = 1'b1;
        tick(3);
        chk(irq_out_n, 1'b0);
        irq_status_any = 1'b0;
        tick(3);
        chk(irq_out_n, 1'b1);
    endtask : t_irq

    task automatic t_wake(input logic pol);
        wake_pol_high = pol;
        tick(3);
        chk(wake_request_out, !pol);
        wake_event = 1'b1;
        tick(1);
        wake_event = 1'b0;
        tick(3);
        chk(wake_request_out, pol);
        wake_clear = 1'b1;
        tick(1);
        wake_clear = 1'b0;
        tick(3);
        chk(wake_request_out, !pol);
        // Event and clear together: the event must win
        wake_event = 1'b1;
        wake_clear = 1'b1;
        tick(1);
        wake_event = 1'b0;
        wake_clear = 1'b0;
        tick(3);
        chk(wake_request_out, pol);
        wake_clear = 1'b1;
        tick(1);
        wake_clear = 1'b0;
        tick(3);
        chk(wake_request_out, !pol);
    endtask : t_wake

    task automatic t_data();
        go(1'b1, 1'b1, 1'b0, 16'h5aa5);
        chk(wcnt, 1);
        chk(core_write_data, 16'h5aa5);
        go(1'b0, 1'b1, 1'b0, 16'h0000);
        chk(rcnt, 1);
        chk(oe_seen, 1'b1);
        chk(shared_bus_lines_out, 16'hc33c);
        chk(shared_bus_lines_oe_n, 1'b1);
    endtask : t_data

    task automatic t_unsel();
        go(1'b1, 1'b0, 1'b0, 16'h1234);
        chk(wcnt, 0);
        go(1'b0, 1'b0, 1'b0, 16'h0000);
        chk(rcnt, 0);
        chk(oe_seen, 1'b0);
        // Selected read with command type high: no data, no drive
        go(1'b0, 1'b1, 1'b1, 16'h0000);
        chk(rcnt, 0);
        chk(oe_seen, 1'b0);
        chk(core_write_data, 16'h5aa5);
    endtask : t_unsel

    task automatic t_addr();
        bus_mode_8bit = 1'b1;
        go(1'b1, 1'b1, 1'b1, 16'hff34);
        go(1'b1, 1'b1, 1'b1, 16'hfffd);
        chk(core_addr, 11'h534);
        chk(wcnt, 0);
        bus_mode_8bit = 1'b0;
        go(1'b1, 1'b1, 1'b1, 16'ha1ff);
        chk(core_addr, 11'h1fc);
        chk(core_byte_en, 4'ha);
    endtask : t_addr

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    initial
    begin
        #40000;
        err_count++;
        summarize();
    end

    initial
    begin
        t_strap(1'b1);
        t_irq();
        t_wake(1'b0);
        t_wake(1'b1);
        t_data();
        t_unsel();
        t_addr();
        t_strap(1'b0);
        summarize();
    end
endmodule : testbench

`default_nettype wire
